/* tb/ifmb_checker.sv */
module ifmb_checker
  import ifmb_pkg::*;
#(
  parameter int NSRC = 22
) (
  // Watched ports
  input wire logic            i_mclk,
  input wire logic            i_rstn,
  input wire ifmb_bus_t       i_bus,
  input wire logic [7:0]      o_rdata,
  input wire ifmb_wdt_mode_t  i_wdt_mode,
  input wire logic [NSRC-1:0] i_src_req,
  input wire logic [NSRC-1:0] i_ack,
  input wire logic [3:0]      i_pin_out_en,
  input wire logic [3:0]      i_pin_out_lvl,
  input wire logic [NSRC-1:0] o_pending
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  wire        wd = i_wdt_mode != IFMB_WDT_INTERVAL;
  wire [15:0] ra = i_bus.rd ? i_bus.addr : 16'h0;
  sequence s_mask_all;
    i_bus.wr && !i_bus.bit_op && i_bus.addr == 16'hffe4 && i_bus.wdata == 8'hff ##1 !i_bus.wr;
  endsequence
  rst_pend_a: assert property ($rose(i_rstn) |-> o_pending == '0) else $error("pending after reset");
  ack_clr_a: assert property (&i_ack && i_src_req == '0 && !i_bus.wr |-> ##2 o_pending == '0)
    else $error("ack left pending");
  wdt_pend_a: assert property (wd [*3] |-> !o_pending[0]) else $error("wdt pending");
  wdt_read_a: assert property (wd && ra == 16'hffe0 |=> !o_rdata[0]) else $error("wdt flag read");
  wdt_mask_a: assert property (wd && ra == 16'hffe4 |=> o_rdata[0] == 1'h0) else $error("wdt mask read");
  req_top_a: assert property (ra == 16'hffe2 |=> o_rdata[7:6] == 2'h0) else $error("req top bits");
  mask_top_a: assert property (ra == 16'hffe6 |=> o_rdata[7:6] == 2'h3) else $error("mask top bits");
  mask_off_a: assert property (s_mask_all |=> o_pending[7:0] == 8'h00) else $error("masked pending");
endmodule : ifmb_checker

bind ifmb_flag_bank ifmb_checker #(.NSRC(NSRC)) chk_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_bus(i_bus),
  .o_rdata(o_rdata), .i_wdt_mode(i_wdt_mode), .i_src_req(i_src_req), .i_ack(i_ack),
  .i_pin_out_en(i_pin_out_en), .i_pin_out_lvl(i_pin_out_lvl), .o_pending(o_pending));

/* tb/ifmb_flag_bank_test.sv */
module ifmb_flag_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ifmb_pkg::*;
  logic           i_mclk = 1'h0;
  logic           i_rstn = 1'h0;
  ifmb_bus_t      bus = '0;
  ifmb_wdt_mode_t mode = IFMB_WDT_INTERVAL;
  logic [3:0]     pen = 4'h0;
  logic [3:0]     plv = 4'h0;
  logic [21:0]    src, ack, pend;
  logic [7:0]     rdata;
  int             bad_count, n_checks, cyc;
  always #10 i_mclk = ~i_mclk;
  ifmb_src_model src_u (.i_mclk(i_mclk), .o_src_req(src), .o_ack(ack));
  ifmb_flag_bank dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_bus(bus), .o_rdata(rdata), .i_wdt_mode(mode),
    .i_src_req(src), .i_ack(ack), .i_pin_out_en(pen), .i_pin_out_lvl(plv), .o_pending(pend));
  task automatic check(input logic [21:0] got, input logic [21:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // Kind k is {write, bit access, bit select}
  task automatic acc(input logic [4:0] k, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #2;
    bus = '{k[4], !k[4], k[3], k[2:0], a, d};
    @(posedge i_mclk);
    #2;
    bus = '0;
  endtask : acc
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    acc(5'h00, a, 8'h00);
    check(22'(rdata), 22'(e));
  endtask : rd
  task automatic pend_is(input logic [21:0] e);
    repeat (2) @(posedge i_mclk);
    #2;
    check(pend, e);
  endtask : pend_is
  task automatic t_reset;
    for (int i = 0; i < 7; i++)
      if (i != 3) rd(16'hffe0 + 16'(i), i < 3 ? 8'h00 : 8'hff);
    pend_is(22'h0);
  endtask : t_reset
  task automatic t_flags;
    acc(5'h10, 16'hffe4, 8'h00);
    src_u.pulse(22'h2, 22'h0);
    pend_is(22'h2);
    src_u.pulse(22'h0, 22'h2);
    pend_is(22'h0);
    acc(5'h1c, 16'hffe0, 8'h10);
    rd(16'hffe0, 8'h10);
    acc(5'h1c, 16'hffe4, 8'h10);
    pend_is(22'h0);
    acc(5'h10, 16'hffe2, 8'hff);
    rd(16'hffe2, 8'h3f);
    acc(5'h10, 16'hffe6, 8'h00);
    rd(16'hffe6, 8'hc0);
    pend_is(22'h3f0000);
  endtask : t_flags
  task automatic t_wdt;
    mode = IFMB_WDT_MODE1;
    acc(5'h18, 16'hffe0, 8'h01);
    rd(16'hffe0, 8'h10);
    mode = IFMB_WDT_MODE2;
    rd(16'hffe4, 8'h10);
    mode = IFMB_WDT_INTERVAL;
    acc(5'h18, 16'hffe0, 8'h01);
    rd(16'hffe0, 8'h11);
  endtask : t_wdt
  task automatic t_pin;
    acc(5'h10, 16'hffe4, 8'hff);
    pen = 4'h1;
    repeat (3) @(posedge i_mclk);
    #2;
    plv = 4'h1;
    repeat (2) @(posedge i_mclk);
    rd(16'hffe0, 8'h13);
    pend_is(22'h3f0000);
  endtask : t_pin
  task automatic t_ack;
    src_u.pulse(22'h0, 22'h3fffff);
    rd(16'hffe2, 8'h00);
  endtask : t_ack
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge i_mclk);
    #2;
    i_rstn = 1'h1;
    t_reset();
    t_flags();
    t_wdt();
    t_pin();
    t_ack();
    stop_test();
  end
endmodule : ifmb_flag_bank_test

/* tb/ifmb_src_model.sv */
module ifmb_src_model (
  // Sources and acknowledge
  input  wire logic   i_mclk,
  output logic [21:0] o_src_req = 22'h0,
  output logic [21:0] o_ack = 22'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // One cycle of requests and acknowledges
  task automatic pulse(input logic [21:0] s, input logic [21:0] a);
    @(posedge i_mclk);
    #2;
    o_src_req = s;
    o_ack = a;
    @(posedge i_mclk);
    #2;
    o_src_req = 22'h0;
    o_ack = 22'h0;
  endtask : pulse
endmodule : ifmb_src_model

/* verilog/ifmb_flag_bank.sv */
`include "ifmb_map.svh"
module ifmb_flag_bank
  import ifmb_pkg::*;
#(
  parameter int NSRC = `IFMB_NUM_SRC
) (
  // Clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_rstn,
  // Register access
  input  wire ifmb_bus_t       i_bus,
  output logic [7:0]           o_rdata,
  // Watchdog mode
  input  wire ifmb_wdt_mode_t  i_wdt_mode,
  // Sources and acknowledge
  input  wire logic [NSRC-1:0] i_src_req,
  input  wire logic [NSRC-1:0] i_ack,
  // Shared port pins
  input  wire logic [3:0]      i_pin_out_en,
  input  wire logic [3:0]      i_pin_out_lvl,
  // Requests towards priority resolution
  output logic [NSRC-1:0]      o_pending
);

  logic [23:0]     req_q;
  logic [23:0]     req_d;
  logic [23:0]     mask_q;
  logic [23:0]     mask_d;
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;
  logic [NSRC-1:0] pend_q;
  logic [NSRC-1:0] pend_d;
  logic [3:0]      lvl_q;
  logic [3:0]      lvl_d;
  logic [3:0]      oen_q;
  logic [3:0]      oen_d;
  logic [NSRC-1:0] src_set;
  logic [3:0]      pin_evt;
  logic [23:0]     wmask;
  logic [23:0]     wval;
  logic            is_req;
  logic            is_mask;
  logic [1:0]      grp;
  logic            wdt_int;

  assign wdt_int = (i_wdt_mode == IFMB_WDT_INTERVAL);

  // Register select
  always_comb begin
    is_req  = 1'b0;
    is_mask = 1'b0;
    grp     = 2'd0;
    case (i_bus.addr)
      `IFMB_ADDR_REQ_A: begin
        is_req = 1'b1;
        grp    = 2'd0;
      end
      `IFMB_ADDR_REQ_B: begin
        is_req = 1'b1;
        grp    = 2'd1;
      end
      `IFMB_ADDR_REQ_C: begin
        is_req = 1'b1;
        grp    = 2'd2;
      end
      `IFMB_ADDR_MASK_A: begin
        is_mask = 1'b1;
        grp     = 2'd0;
      end
      `IFMB_ADDR_MASK_B: begin
        is_mask = 1'b1;
        grp     = 2'd1;
      end
      `IFMB_ADDR_MASK_C: begin
        is_mask = 1'b1;
        grp     = 2'd2;
      end
      default: begin
        is_req  = 1'b0;
        is_mask = 1'b0;
      end
    endcase
  end

  // Write lane mask and value, bit or byte
  always_comb begin
    logic [7:0] lane;
    lane  = 8'h00;
    wmask = 24'h000000;
    wval  = 24'h000000;
    if (i_bus.wr && (is_req || is_mask)) begin
      lane = i_bus.bit_op ? (8'h01 << i_bus.bit_sel) : 8'hff;
      case (grp)
        2'd0: begin
          wmask = {16'h0000, lane};
          wval  = {16'h0000, i_bus.wdata};
        end
        2'd1: begin
          wmask = {8'h00, lane, 8'h00};
          wval  = {8'h00, i_bus.wdata, 8'h00};
        end
        default: begin
          wmask = {lane & `IFMB_REQ_C_USED, 16'h0000};
          wval  = {i_bus.wdata, 16'h0000};
        end
      endcase
    end
  end

  // Pin edges while driven as outputs
  for (genvar g = 0; g < `IFMB_NUM_PINS; g++) begin : g_pin
    assign pin_evt[g] = oen_q[g] & i_pin_out_en[g] & (lvl_q[g] ^ i_pin_out_lvl[g]);
  end

  // Source events
  always_comb begin
    src_set = i_src_req | (NSRC'(pin_evt) << `IFMB_BIT_PIN0);
  end

  // Flag next state
  always_comb begin
    logic [23:0] sw_req_m;
    sw_req_m = wmask;
    if (!wdt_int) begin
      sw_req_m[`IFMB_BIT_WDT] = 1'b0;
    end
    req_d  = req_q;
    mask_d = mask_q;
    if (is_req) begin
      req_d = (req_q & ~sw_req_m) | (wval & sw_req_m);
    end
    if (is_mask) begin
      mask_d = (mask_q & ~wmask) | (wval & wmask);
    end
    req_d[NSRC-1:0] = req_d[NSRC-1:0] & ~i_ack;
    req_d[NSRC-1:0] = req_d[NSRC-1:0] | src_set;
    req_d[23:NSRC]  = '0;
    if (!wdt_int) begin
      req_d[`IFMB_BIT_WDT] = 1'b0;
    end
    mask_d[23:NSRC] = '1;
    lvl_d = i_pin_out_lvl;
    oen_d = i_pin_out_en;
  end

  // Read data and forwarded requests
  always_comb begin
    logic [23:0] rview;
    rview = 24'h000000;
    if (is_req) begin
      rview = req_q;
      if (!wdt_int) begin
        rview[`IFMB_BIT_WDT] = 1'b0;
      end
    end else if (is_mask) begin
      rview = mask_q;
      if (!wdt_int) begin
        rview[`IFMB_BIT_WDT] = `IFMB_UNDEF_VAL;
      end
    end
    rview[23:22] = is_mask ? 2'b11 : 2'b00;
    case (grp)
      2'd0:    rdata_d = rview[7:0];
      2'd1:    rdata_d = rview[15:8];
      default: rdata_d = rview[23:16];
    endcase
    if (!(i_bus.rd && (is_req || is_mask))) begin
      rdata_d = rdata_q;
    end
    pend_d = req_d[NSRC-1:0] & ~mask_d[NSRC-1:0];
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_q   <= {3{`IFMB_RST_REQ}};
      mask_q  <= {3{`IFMB_RST_MASK}};
      rdata_q <= 8'h00;
      pend_q  <= '0;
      lvl_q   <= 4'h0;
      oen_q   <= 4'h0;
    end else begin
      req_q   <= req_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
      pend_q  <= pend_d;
      lvl_q   <= lvl_d;
      oen_q   <= oen_d;
    end
  end

  assign o_rdata   = rdata_q;
  assign o_pending = pend_q;

endmodule : ifmb_flag_bank

/* verilog/ifmb_map.svh */
`ifndef IFMB_MAP_SVH
`define IFMB_MAP_SVH
`define IFMB_ADDR_REQ_A   16'hffe0
`define IFMB_ADDR_REQ_B   16'hffe1
`define IFMB_ADDR_REQ_C   16'hffe2
`define IFMB_ADDR_MASK_A  16'hffe4
`define IFMB_ADDR_MASK_B  16'hffe5
`define IFMB_ADDR_MASK_C  16'hffe6
`define IFMB_RST_REQ      8'h00
`define IFMB_RST_MASK     8'hff
`define IFMB_REQ_C_USED   8'h3f
`define IFMB_MASK_C_FIXED 8'hc0
`define IFMB_BIT_WDT      0
`define IFMB_BIT_PIN0     1
`define IFMB_NUM_PINS     4
`define IFMB_NUM_SRC      22
`define IFMB_UNDEF_VAL    1'b0
`endif

/* verilog/ifmb_pkg.sv */
package ifmb_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [2:0]  bit_sel;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ifmb_bus_t;
  typedef enum logic [1:0] {
    IFMB_WDT_INTERVAL,
    IFMB_WDT_MODE1,
    IFMB_WDT_MODE2
  } ifmb_wdt_mode_t;
endpackage : ifmb_pkg
